// ==== design/bcs_pkg.sv ====
// Package for the backlash compensation sequencer: register map, reset values, types
package bcs_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] BCS_OFS_CTRL = 8'h00;
    localparam logic [7:0] BCS_OFS_TIMES = 8'h04;
    localparam logic [7:0] BCS_OFS_TIMEOUT = 8'h08;
    localparam logic [7:0] BCS_OFS_REF = 8'h0C;
    localparam logic [7:0] BCS_OFS_STATUS = 8'h10;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BCS_CTRL_MODE_LSB = 0;
    localparam int BCS_CTRL_TYPE_BIT = 2;
    localparam int BCS_CTRL_WAIT_BIT = 3;
    localparam int BCS_CTRL_REACT_BIT = 4;
    localparam int BCS_TIMES_FOLLOW_LSB = 16;
    localparam int BCS_STATUS_FAULT_BIT = 4;
    localparam int BCS_STATUS_IDX_LSB = 8;

    // ----------------------------------------------------------------
    // Times in tenths of a second, clock and tick length, speed reference constants
    // ----------------------------------------------------------------
    localparam int BCS_CLK_HZ = 100000000;
    localparam int BCS_TICK_MS = 100;
    localparam int BCS_TICK_CYCLES = BCS_CLK_HZ / 1000 * BCS_TICK_MS;
    localparam logic [15:0] BCS_CHECK_DELAY_RST = 16'h0005;
    localparam logic [15:0] BCS_FOLLOW_TIME_RST = 16'h0005;
    localparam logic [15:0] BCS_FOLLOW_TIME_MAX = 16'h03E8;
    localparam logic [15:0] BCS_TIMEOUT_RST = 16'h0032;
    localparam logic [15:0] BCS_REF_PERCENT_DIV = 16'h0064;
    localparam logic [15:0] BCS_REF_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BCS_MODE_OFF,
        BCS_MODE_START,
        BCS_MODE_START_DIR,
        BCS_MODE_MASTER_REQ
    } bcs_mode_t;

    typedef enum logic [2:0] {
        BCS_ST_IDLE,
        BCS_ST_FOLLOW,
        BCS_ST_RAMP,
        BCS_ST_CHECK,
        BCS_ST_RUN,
        BCS_ST_REV_STOP,
        BCS_ST_ZERO_HOLD,
        BCS_ST_FAULT
    } bcs_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic run_order;
        logic halt;
        logic dir_reverse;
        logic closed_loop;
        logic sync_motor;
        logic torque_at_limit;
        logic motion_stopped;
        logic multi_drive_link;
        logic role_master;
        logic expert_access;
    } bcs_drive_in_t;

    typedef struct packed {
        logic run_enable;
        logic comp_active;
        logic torque_limit_en;
        logic resume_from_limit;
        logic force_speed_ctrl;
        logic drive_stop;
        logic zero_speed_hold;
        logic freewheel;
        logic comp_fault;
        logic report_done;
    } bcs_drive_out_t;

endpackage

// ==== design/bcs_sequencer.sv ====
// Backlash compensation sequencer with APB register slave and follower coordination
//
// Summary of operation
// - Mode selects off (reset), on start, start plus reversal, or master request.
// - Start mode compensates whenever run order appears or halt is removed.
// - Start-plus-reversal mode also compensates each time commanded direction reverses while running.
// - Master-request mode compensates only when the coordinating master asks.
// - Ramp under torque limit until load stalls motion, then run from that torque.
// - Reversal uses stop-and-restart in open loop, zero-speed hold in closed loop.
// - Start-only compensation acts while starting and does nothing once running.
// - Open loop reversal: stop, and if run order persists restart with compensation.
// - Closed loop reversal: hold zero speed, compensate, then return to running.
// - Direct sequential: followers compensate one by one, each for a set time.
// - Direct simultaneous: all followers compensate together for the set time.
// - Controlled sequential: followers report in turn; master goes after the last.
// - Controlled simultaneous: all followers report; master goes after the last.
// - Sequencing type usable only when enabled, multi-drive link and master role.
// - Report waiting (default yes) also needs expert access to change.
// - Without reports master waits a set follower time, 0.5 s, up to 100 s.
// - Compensation speed is settable, default 1% of selected nominal frequency.
// - Works the same in torque control and in speed control.
// - Torque limit is checked only after a set delay from ramp start.
// - On failure either ignore it or stop freewheeling (default).
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps

module bcs_sequencer
    import bcs_pkg::*;
#(
    parameter int NUM_FOLLOWERS = 2,
    parameter int TICK_CYCLES = bcs_pkg::BCS_TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive state, same clock
    input wire bcs_pkg::bcs_drive_in_t drive_in,
    input wire logic [15:0] async_nominal_freq,
    input wire logic [15:0] sync_nominal_freq,
    // Drive-to-drive link pins
    input wire logic [NUM_FOLLOWERS-1:0] follower_done_pin,
    input wire logic master_request_pin,
    output logic [NUM_FOLLOWERS-1:0] follower_start,
    // Drive commands
    output bcs_pkg::bcs_drive_out_t drive_out,
    output logic [15:0] comp_speed_ref,
    output logic comp_dir_reverse
);
    import bcs_pkg::*;

    localparam int IDXW = (NUM_FOLLOWERS > 1) ? $clog2(NUM_FOLLOWERS) : 1;
    localparam int TICKW = $clog2(TICK_CYCLES + 1);
    localparam logic [IDXW-1:0] LAST_IDX = IDXW'(NUM_FOLLOWERS - 1);

    typedef struct packed {
        bcs_state_t state;
        logic [TICKW-1:0] tick_cnt;
        logic [15:0] timer;
        logic [IDXW-1:0] fidx;
        logic run_ok_q;
        logic dir_q;
        logic [NUM_FOLLOWERS-1:0] done_s1;
        logic [NUM_FOLLOWERS-1:0] done_s2;
        logic mreq_s1;
        logic mreq_s2;
        logic mreq_q;
        bcs_mode_t mode;
        logic seq_simul;
        logic wait_reports;
        logic react_freewheel;
        logic [15:0] check_delay;
        logic [15:0] follow_time;
        logic [15:0] timeout;
        logic [15:0] ref_set;
        logic fault;
        logic report;
        logic resume;
        logic [15:0] spd;
        logic comp_dir;
    } bcs_regs_t;

    bcs_regs_t r;
    bcs_regs_t next_r;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic bus_write(input logic [7:0] ofs);
        bus_write = psel && penable && pwrite && clk_en && (paddr == ofs);
    endfunction

    logic run_ok;
    logic start_evt;
    logic reverse_evt;
    logic mreq_evt;
    logic coordinator;
    logic expert_ok;
    logic eff_simul;
    logic eff_wait;
    logic tick;
    logic mapped;
    logic [15:0] nominal;
    logic follow_step_done;

    always_comb begin
        run_ok = drive_in.run_order && !drive_in.halt;
        start_evt = run_ok && !r.run_ok_q;
        reverse_evt = (drive_in.dir_reverse != r.dir_q);
        mreq_evt = r.mreq_s2 && !r.mreq_q;
        coordinator = (r.mode != BCS_MODE_OFF) && drive_in.multi_drive_link
            && drive_in.role_master;
        expert_ok = coordinator && drive_in.expert_access;
        eff_simul = coordinator && r.seq_simul;
        eff_wait = !expert_ok || r.wait_reports;
        tick = (r.tick_cnt == TICKW'(TICK_CYCLES - 1));
        mapped = (paddr == BCS_OFS_CTRL) || (paddr == BCS_OFS_TIMES)
            || (paddr == BCS_OFS_TIMEOUT) || (paddr == BCS_OFS_REF)
            || (paddr == BCS_OFS_STATUS);
        nominal = drive_in.sync_motor ? sync_nominal_freq : async_nominal_freq;
        // Reports or the timer, depending on the follower strategy
        if (eff_wait) begin
            if (eff_simul) begin
                follow_step_done = &r.done_s2;
            end else begin
                follow_step_done = r.done_s2[r.fidx];
            end
        end else begin
            // Only a tick edge ends the wait, so the free tick phase never shortens it
            follow_step_done = (r.timer >= r.follow_time) && tick;
        end
    end

    // ----------------------------------------------------------------
    // APB read side
    // ----------------------------------------------------------------
    always_comb begin
        pready = clk_en;
        pslverr = psel && penable && !mapped;
        prdata = 32'h0000_0000;
        unique case (paddr)
            BCS_OFS_CTRL: begin
                prdata[BCS_CTRL_MODE_LSB +: 2] = r.mode;
                prdata[BCS_CTRL_TYPE_BIT] = r.seq_simul;
                prdata[BCS_CTRL_WAIT_BIT] = r.wait_reports;
                prdata[BCS_CTRL_REACT_BIT] = r.react_freewheel;
            end
            BCS_OFS_TIMES: begin
                prdata = {r.follow_time, r.check_delay};
            end
            BCS_OFS_TIMEOUT: begin
                prdata[15:0] = r.timeout;
            end
            BCS_OFS_REF: begin
                prdata[15:0] = r.ref_set;
            end
            BCS_OFS_STATUS: begin
                prdata[2:0] = r.state;
                prdata[BCS_STATUS_FAULT_BIT] = r.fault;
                prdata[BCS_STATUS_IDX_LSB +: IDXW] = r.fidx;
            end
            default: begin
                prdata = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (clk_en) begin
            // Link pins are foreign; the first stage is never looked at
            next_r.done_s1 = follower_done_pin;
            next_r.done_s2 = r.done_s1;
            next_r.mreq_s1 = master_request_pin;
            next_r.mreq_s2 = r.mreq_s1;
            next_r.mreq_q = r.mreq_s2;
            next_r.run_ok_q = run_ok;
            next_r.dir_q = drive_in.dir_reverse;
            next_r.resume = 1'b0;
            next_r.tick_cnt = tick ? '0 : r.tick_cnt + 1'b1;
            if (tick && r.timer != 16'hFFFF) begin
                next_r.timer = r.timer + 16'h0001;
            end
            // Default speed tracks 1% of the nominal frequency in use
            next_r.spd = (r.ref_set == 16'h0000) ? nominal / BCS_REF_PERCENT_DIV
                : r.ref_set;

            // Register writes
            if (bus_write(BCS_OFS_CTRL)) begin
                next_r.mode = bcs_mode_t'(pwdata[BCS_CTRL_MODE_LSB +: 2]);
                next_r.react_freewheel = pwdata[BCS_CTRL_REACT_BIT];
                if (coordinator) begin
                    next_r.seq_simul = pwdata[BCS_CTRL_TYPE_BIT];
                end
                if (expert_ok) begin
                    next_r.wait_reports = pwdata[BCS_CTRL_WAIT_BIT];
                end
            end
            if (bus_write(BCS_OFS_TIMES)) begin
                next_r.check_delay = pwdata[15:0];
                if (expert_ok) begin
                    // Clamped: the follower time tops out at 100 s
                    next_r.follow_time = (pwdata[31:16] > BCS_FOLLOW_TIME_MAX) ?
                        BCS_FOLLOW_TIME_MAX : pwdata[BCS_TIMES_FOLLOW_LSB +: 16];
                end
            end
            if (bus_write(BCS_OFS_TIMEOUT)) begin
                next_r.timeout = pwdata[15:0];
            end
            if (bus_write(BCS_OFS_REF)) begin
                next_r.ref_set = pwdata[15:0];
            end
            if (bus_write(BCS_OFS_STATUS) && pwdata[BCS_STATUS_FAULT_BIT]) begin
                next_r.fault = 1'b0;
            end

            // Sequencer; the control type never enters here, torque or speed alike
            unique case (r.state)
                BCS_ST_IDLE: begin
                    next_r.report = 1'b0;
                    if (start_evt) begin
                        next_r.comp_dir = drive_in.dir_reverse;
                        next_r.timer = 16'h0000;
                        next_r.fidx = '0;
                        if (r.mode == BCS_MODE_START || r.mode == BCS_MODE_START_DIR) begin
                            next_r.state = coordinator ? BCS_ST_FOLLOW
                                : BCS_ST_RAMP;
                        end else if (r.mode == BCS_MODE_MASTER_REQ && r.mreq_s2) begin
                            next_r.state = BCS_ST_RAMP;
                        end else begin
                            next_r.state = BCS_ST_RUN;
                        end
                    end
                end
                BCS_ST_FOLLOW: begin
                    if (!run_ok) begin
                        next_r.state = BCS_ST_IDLE;
                    end else if (follow_step_done) begin
                        next_r.timer = 16'h0000;
                        if (eff_simul || r.fidx == LAST_IDX) begin
                            next_r.state = BCS_ST_RAMP;
                        end else begin
                            next_r.fidx = r.fidx + 1'b1;
                        end
                    end
                end
                BCS_ST_RAMP: begin
                    if (!run_ok) begin
                        next_r.state = BCS_ST_IDLE;
                    end else if (r.timer >= r.check_delay && tick) begin
                        next_r.timer = 16'h0000;
                        next_r.state = BCS_ST_CHECK;
                    end
                end
                BCS_ST_CHECK: begin
                    if (!run_ok) begin
                        next_r.state = BCS_ST_IDLE;
                    end else if (drive_in.torque_at_limit && drive_in.motion_stopped) begin
                        next_r.resume = 1'b1;
                        next_r.report = (r.mode == BCS_MODE_MASTER_REQ);
                        next_r.state = BCS_ST_RUN;
                    end else if (r.timer >= r.timeout) begin
                        next_r.fault = 1'b1;
                        next_r.state = r.react_freewheel ? BCS_ST_FAULT
                            : BCS_ST_RUN;
                    end
                end
                BCS_ST_RUN: begin
                    if (!run_ok) begin
                        next_r.state = BCS_ST_IDLE;
                    end else if (r.mode == BCS_MODE_MASTER_REQ && mreq_evt) begin
                        next_r.timer = 16'h0000;
                        next_r.comp_dir = drive_in.dir_reverse;
                        next_r.state = BCS_ST_RAMP;
                    end else if (r.mode == BCS_MODE_START_DIR && reverse_evt) begin
                        next_r.comp_dir = drive_in.dir_reverse;
                        next_r.state = drive_in.closed_loop ? BCS_ST_ZERO_HOLD
                            : BCS_ST_REV_STOP;
                    end
                    // Start-only mode stays out of the way here
                    if (r.mode != BCS_MODE_MASTER_REQ) begin
                        next_r.report = 1'b0;
                    end else if (!r.mreq_s2) begin
                        next_r.report = 1'b0;
                    end
                end
                BCS_ST_REV_STOP: begin
                    if (!run_ok) begin
                        next_r.state = BCS_ST_IDLE;
                    end else if (drive_in.motion_stopped) begin
                        next_r.timer = 16'h0000;
                        next_r.fidx = '0;
                        next_r.comp_dir = drive_in.dir_reverse;
                        next_r.state = coordinator ? BCS_ST_FOLLOW : BCS_ST_RAMP;
                    end
                end
                BCS_ST_ZERO_HOLD: begin
                    if (!run_ok) begin
                        next_r.state = BCS_ST_IDLE;
                    end else if (drive_in.motion_stopped) begin
                        next_r.timer = 16'h0000;
                        next_r.fidx = '0;
                        next_r.comp_dir = drive_in.dir_reverse;
                        next_r.state = coordinator ? BCS_ST_FOLLOW : BCS_ST_RAMP;
                    end
                end
                BCS_ST_FAULT: begin
                    // Freewheel until the run order goes away or halt is applied
                    if (!run_ok) begin
                        next_r.state = BCS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{
                state: BCS_ST_IDLE,
                tick_cnt: '0,
                timer: 16'h0000,
                fidx: '0,
                run_ok_q: 1'b0,
                dir_q: 1'b0,
                done_s1: '0,
                done_s2: '0,
                mreq_s1: 1'b0,
                mreq_s2: 1'b0,
                mreq_q: 1'b0,
                mode: BCS_MODE_OFF,
                seq_simul: 1'b0,
                wait_reports: 1'b1,
                react_freewheel: 1'b1,
                check_delay: BCS_CHECK_DELAY_RST,
                follow_time: BCS_FOLLOW_TIME_RST,
                timeout: BCS_TIMEOUT_RST,
                ref_set: BCS_REF_RST,
                fault: 1'b0,
                report: 1'b0,
                resume: 1'b0,
                spd: 16'h0000,
                comp_dir: 1'b0
            };
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic in_comp;
    logic master_waits;

    always_comb begin
        in_comp = (r.state == BCS_ST_RAMP) || (r.state == BCS_ST_CHECK);
        master_waits = (r.state == BCS_ST_FOLLOW);
        drive_out.run_enable = (r.state == BCS_ST_RUN);
        drive_out.comp_active = in_comp;
        drive_out.torque_limit_en = in_comp;
        drive_out.resume_from_limit = r.resume;
        drive_out.force_speed_ctrl = in_comp && (r.mode == BCS_MODE_MASTER_REQ);
        drive_out.drive_stop = (r.state == BCS_ST_REV_STOP)
            || (master_waits && !drive_in.closed_loop);
        drive_out.zero_speed_hold = (r.state == BCS_ST_ZERO_HOLD)
            || (master_waits && drive_in.closed_loop);
        drive_out.freewheel = (r.state == BCS_ST_FAULT);
        drive_out.comp_fault = r.fault;
        drive_out.report_done = r.report;
        comp_speed_ref = r.spd;
        comp_dir_reverse = r.comp_dir;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FOLLOWERS; gi++) begin : g_fstart
            // Sequential keeps a follower started until it reports or its slot ends
            assign follower_start[gi] = master_waits
                && (eff_simul || r.fidx == IDXW'(gi));
        end
    endgenerate

endmodule

// ==== verification/bcs_follower_model.sv ====
// Follower drives on the link: report completion some cycles after a start order
`timescale 1ns/10ps
module bcs_follower_model #(parameter int N = 2) (
    // Link
    input wire logic pclk,
    input wire logic [7:0] lat,
    input wire logic [N-1:0] start,
    output logic [N-1:0] done
);
    int cnt [N] = '{default: 0};
    initial done = '0;
    // Report is a level that drops with the order; a large lat only delays it
    always @(posedge pclk) begin
        for (int i = 0; i < N; i++) begin
            cnt[i] <= start[i] ? cnt[i] + 1 : 0;
            done[i] <= start[i] && cnt[i] >= lat;
        end
    end
endmodule

// ==== verification/bcs_sequencer_props.sv ====
// Port checker for the backlash compensation sequencer
`timescale 1ns/10ps
module bcs_sequencer_props
    import bcs_pkg::*;
#(parameter int NUM_FOLLOWERS = 2) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire bcs_pkg::bcs_drive_in_t drive_in,
    input wire logic master_request_pin,
    input wire logic [NUM_FOLLOWERS-1:0] follower_start,
    input wire bcs_pkg::bcs_drive_out_t drive_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    lim_excl_a:
    assert property (!(drive_out.run_enable && drive_out.torque_limit_en)) else $error("run in ramp");
    resume_cause_a:
    assert property (drive_out.resume_from_limit |-> drive_out.run_enable
        && $past(drive_in.torque_at_limit && drive_in.motion_stopped)) else $error("bad resume");
    resume_pulse_a:
    assert property (drive_out.resume_from_limit |=> !drive_out.resume_from_limit)
        else $error("resume too long");
    abandon_a:
    assert property (!drive_in.run_order |=> !drive_out.run_enable && !drive_out.torque_limit_en)
        else $error("sequence not abandoned");
    fault_stop_a:
    assert property ($rose(drive_out.freewheel) |-> drive_out.comp_fault) else $error("no fault");
    zero_hold_a:
    assert property ($rose(drive_out.zero_speed_hold) |-> $past(drive_in.closed_loop))
        else $error("zero hold in open loop");
    master_wait_a:
    assert property (|follower_start |-> !drive_out.run_enable && !drive_out.torque_limit_en
        && (drive_out.zero_speed_hold || drive_out.drive_stop)) else $error("master moved");
    follower_shape_a:
    assert property ($onehot0(follower_start) || &follower_start) else $error("bad starts");
    run_keep_a:
    assert property (drive_out.run_enable && drive_in.run_order && !drive_in.halt
        && !$past(master_request_pin, 2) && $stable(drive_in.dir_reverse)
        && $past(drive_in.dir_reverse) == $past(drive_in.dir_reverse, 2)
        |=> drive_out.run_enable) else $error("left running");
    cover property (drive_out.resume_from_limit);
    cover property ($rose(drive_out.zero_speed_hold));
    cover property (&follower_start);
endmodule
bind bcs_sequencer bcs_sequencer_props #(.NUM_FOLLOWERS(NUM_FOLLOWERS)) props (.pclk(pclk),
    .presetn(presetn), .drive_in(drive_in), .master_request_pin(master_request_pin),
    .follower_start(follower_start), .drive_out(drive_out));

// ==== verification/testbench.sv ====
// Self-checking bench for the backlash compensation sequencer
`timescale 1ns/10ps
module testbench;
    import bcs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mreq = 0, er, cdir;
    logic [7:0] paddr = 0, lat = 8'h04;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr;
    logic [1:0] fstart, fdone;
    logic [15:0] aref = 16'h1388, sref = 16'h0BB8, cref;
    bcs_drive_in_t din = '0;
    bcs_drive_out_t dout;
    int fail_count = 0, checks = 0, cyc = 0, n;
    always #5 pclk = ~pclk;
    bcs_sequencer #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_in(din),
        .async_nominal_freq(aref), .sync_nominal_freq(sref), .follower_done_pin(fdone),
        .master_request_pin(mreq), .follower_start(fstart), .drive_out(dout),
        .comp_speed_ref(cref), .comp_dir_reverse(cdir));
    bcs_follower_model fm (.pclk(pclk), .lat(lat), .start(fstart), .done(fdone));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", s, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task go(input logic r);
        @(posedge pclk);
        din.run_order <= r;
    endtask
    task conclude();
        $display("checks %0d errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regs();
        apb(0, BCS_OFS_CTRL, 0);
        chk("ctrl", rd, 32'h18);
        apb(0, BCS_OFS_TIMES, 0);
        chk("times", rd, 32'h00050005);
        apb(0, 8'h20, 0);
        chk("unmapped", er, 1);
        apb(1, BCS_OFS_TIMES, 32'h00010002);
        apb(1, BCS_OFS_TIMEOUT, 32'h6);
        go(1);
        repeat (2) @(posedge pclk);
        chk("off", {dout.run_enable, dout.torque_limit_en}, 2'b10);
        go(0);
    endtask
    task t_start();
        apb(1, BCS_OFS_CTRL, 32'h11);
        din.torque_at_limit <= 1;
        din.motion_stopped <= 1;
        go(1);
        wait (dout.torque_limit_en === 1'b1);
        n = 0;
        while (dout.run_enable !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
        chk("delay", n >= 8, 1);
        chk("resume", dout.resume_from_limit, 1);
        chk("ref", cref, 16'd50);
        din.sync_motor <= 1;
        din.dir_reverse <= 1;
        repeat (4) @(posedge pclk);
        chk("ref_sync", cref, 16'd30);
        chk("no_rev", dout.run_enable, 1);
        din.halt <= 1;
        @(posedge pclk);
        din.halt <= 0;
        repeat (3) @(posedge pclk);
        chk("restart", dout.torque_limit_en, 1);
        go(0);
        repeat (2) @(posedge pclk);
        chk("abandon", {dout.run_enable, dout.torque_limit_en}, 0);
    endtask
    task rev(input logic cl, input logic d);
        din.closed_loop <= cl;
        din.motion_stopped <= 0;
        din.dir_reverse <= d;
        repeat (3) @(posedge pclk);
        chk("rev_hold", {dout.zero_speed_hold, dout.drive_stop}, {cl, !cl});
        din.motion_stopped <= 1;
        wait (dout.run_enable === 1'b1);
        chk("rev_dir", cdir, d);
    endtask
    task t_rev();
        apb(1, BCS_OFS_CTRL, 32'h12);
        go(1);
        wait (dout.run_enable === 1'b1);
        rev(1, 0);
        rev(0, 1);
        go(0);
    endtask
    task t_fault(input logic [31:0] c);
        apb(1, BCS_OFS_STATUS, 32'h10);
        apb(1, BCS_OFS_CTRL, c);
        din.torque_at_limit <= 0;
        go(1);
        wait (dout.comp_fault === 1'b1);
        repeat (2) @(posedge pclk);
        chk("react", {dout.freewheel, dout.run_enable}, {c[4], !c[4]});
        go(0);
    endtask
    task t_coord(input logic [31:0] c, input logic [1:0] first, input logic [7:0] l);
        lat <= l;
        apb(1, BCS_OFS_CTRL, c);
        go(1);
        wait (fstart !== 2'b00);
        chk("first", fstart, first);
        wait (dout.run_enable === 1'b1);
        chk("master_run", dout.resume_from_limit, 1);
        go(0);
    endtask
    task t_req();
        din.role_master <= 0;
        apb(1, BCS_OFS_CTRL, 32'h13);
        go(1);
        repeat (4) @(posedge pclk);
        chk("no_self", {dout.run_enable, dout.torque_limit_en}, 2'b10);
        mreq <= 1;
        wait (dout.torque_limit_en === 1'b1);
        chk("speed_ctrl", {dout.force_speed_ctrl, dout.comp_active}, 2'b11);
        wait (dout.run_enable === 1'b1);
        chk("report", dout.report_done, 1);
        mreq <= 0;
        go(0);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_start();
        t_rev();
        t_fault(32'h11);
        t_fault(32'h01);
        din.torque_at_limit <= 1;
        din.multi_drive_link <= 1;
        din.role_master <= 1;
        din.expert_access <= 1;
        t_coord(32'h19, 2'b01, 8'h04);
        t_coord(32'h1D, 2'b11, 8'h04);
        t_coord(32'h11, 2'b01, 8'hFF);
        t_req();
        conclude();
    end
endmodule
